// ### core/tws_pkg.sv
/*
 Package for the two-wire slave transmitter: register map, field positions,
 status codes, state encoding and the carrier structs shared by the files.
 Assumes a 32-bit APB master and a 200 MHz mclk.
*/
// Behaviour
// - Answer the upper seven address bits; bit zero enables general call 0x00.
// - Wait for own or general call address; read bit selects transmit.
// - After address and direction, set the flag and a valid status.
// - Status 0xA8: read address acked; next byte last if acknowledge off.
// - Status 0xB0: lost arbitration then addressed for read; as 0xA8.
// - Status 0xB8: byte sent and acked; next byte as 0xA8.
// - Status 0xC0: byte not acked; go unaddressed, recognise if acknowledge on.
// - Status 0xC8: last byte acked anyway; go unaddressed as 0xC0.
// - Start request written in 0xC0 or 0xC8 sends START when bus free; here it is only kept pending and no START is driven.
// - Acknowledge cleared mid transfer: one last byte, then master reads ones.
// - Acknowledge off ignores own address but bus is still monitored.
// - In deep sleep with acknowledge on, still match address and wake part.
// - After wake match, hold clock low until software clears the flag.
// - Data register content after wake is not guaranteed.
// - Status 0x00 on misplaced START or STOP; stop request releases lines.
// - Status 0xF8 while the flag is clear.
package tws_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] TWS_OFS_DATA   = 8'h00;
   localparam logic [7:0] TWS_OFS_STATUS = 8'h04;
   localparam logic [7:0] TWS_OFS_ADDR   = 8'h08;
   localparam logic [7:0] TWS_OFS_CTRL   = 8'h0C;
   localparam logic [7:0] TWS_OFS_POWER  = 8'h10;
   // ==========================================================
   // Control field positions
   localparam int TWS_CTL_INT = 7;
   localparam int TWS_CTL_ACK = 6;
   localparam int TWS_CTL_STA = 5;
   localparam int TWS_CTL_STO = 4;
   localparam int TWS_CTL_WC  = 3;
   localparam int TWS_CTL_EN  = 2;
   localparam int TWS_CTL_IE  = 0;
   // ==========================================================
   // Reset values
   localparam logic [7:0] TWS_RST_ADDR = 8'h00;
   localparam logic [7:0] TWS_RST_DATA = 8'hFF;
   // ==========================================================
   // Status codes
   localparam logic [7:0] TWS_ST_SLA_R  = 8'hA8;
   localparam logic [7:0] TWS_ST_ARB_R  = 8'hB0;
   localparam logic [7:0] TWS_ST_DAT_A  = 8'hB8;
   localparam logic [7:0] TWS_ST_DAT_N  = 8'hC0;
   localparam logic [7:0] TWS_ST_LAST_A = 8'hC8;
   localparam logic [7:0] TWS_ST_BUSERR = 8'h00;
   localparam logic [7:0] TWS_ST_NONE   = 8'hF8;
   localparam logic [6:0] TWS_GC_ADDR   = 7'h00;
   // ==========================================================
   // Timing
   localparam int TWS_CLK_MHZ   = 200;
   localparam int TWS_HOLD_NS   = 250;
   localparam int TWS_HOLD_CYC  = (TWS_HOLD_NS*TWS_CLK_MHZ+999)/1000;
   // ==========================================================
   // Bus states, gray in listed order; WAIT to TXB flips two bits
   typedef enum logic [2:0] {
      TWS_IDLE  = 3'b000,
      TWS_ADDR  = 3'b001,
      TWS_AACK  = 3'b011,
      TWS_TXB   = 3'b010,
      TWS_RACK  = 3'b110,
      TWS_WAIT  = 3'b111,
      TWS_IGN   = 3'b101
   } tws_state_e;
   // Line events from the sampler
   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } tws_line_s;
   // Pin drive
   typedef struct packed {
      logic scl_oe;
      logic sda_oe;
   } tws_drv_s;
endpackage

// ### core/tws_line_sync.sv
/*
 Two-flop synchroniser and edge finder for SCL and SDA.
 Assumes pins are asynchronous to mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module tws_line_sync (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output tws_pkg::tws_line_s    line
);
   import tws_pkg::*;
   logic [1:0] scl_r;
   logic [1:0] sda_r;
   logic       scl_d_r;
   logic       sda_d_r;
   // ==========================================================
   // Synchronise, then keep one older copy
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scl_r   <= 2'b11;
         sda_r   <= 2'b11;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_r   <= {scl_r[0], scl_i};
         sda_r   <= {sda_r[0], sda_i};
         scl_d_r <= scl_r[1];
         sda_d_r <= sda_r[1];
      end
   end
   // Edges and bus conditions from the second stage and its older copy
   always_comb begin
      line.scl      = scl_r[1];
      line.sda      = sda_r[1];
      line.scl_rise = scl_r[1] & ~scl_d_r;
      line.scl_fall = ~scl_r[1] & scl_d_r;
      line.start    = scl_r[1] & scl_d_r & ~sda_r[1] & sda_d_r;
      line.stop     = scl_r[1] & scl_d_r & sda_r[1] & ~sda_d_r;
   end
endmodule
`default_nettype wire

// ### core/tws_apb_regs.sv
/*
 APB slave register decode helper: word select and read mux.
 Assumes 32-bit APB, zero wait states.
*/
`timescale 1ns/100ps
`default_nettype none
module tws_apb_regs (
   input  wire logic [7:0]  paddr,
   input  wire logic [7:0]  data_q,
   input  wire logic [7:0]  status_q,
   input  wire logic [7:0]  addr_q,
   input  wire logic [7:0]  ctrl_q,
   input  wire logic        sleep_q,
   output logic [31:0]      rdata,
   output logic             slverr
);
   import tws_pkg::*;
   // Read mux; unmapped words answer zero with an error
   always_comb begin
      rdata  = 32'h0000_0000;
      slverr = 1'b0;
      case (paddr)
         TWS_OFS_DATA:   rdata[7:0] = data_q;
         TWS_OFS_STATUS: rdata[7:0] = status_q;
         TWS_OFS_ADDR:   rdata[7:0] = addr_q;
         TWS_OFS_CTRL:   rdata[7:0] = ctrl_q;
         TWS_OFS_POWER:  rdata[0]   = sleep_q;
         default:        slverr     = 1'b1;
      endcase
   end
endmodule
`default_nettype wire

// ### core/tws_top.sv
/*
 Two-wire slave transmitter with APB registers.
 Assumes open-drain pins resolved outside; sleep level from the power unit.
*/
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tws_top (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             wake,
   output logic             irq
);
   import tws_pkg::*;
   tws_line_s  line;
   tws_state_e st_r;
   logic [7:0] addr_r;
   logic [7:0] ctrl_r;
   logic [7:0] data_r;
   logic [7:0] status_r;
   logic [7:0] shift_r;
   logic [3:0] bit_r;
   logic       flag_r;
   logic       last_r;
   logic       start_pend_r;
   logic       sleep_r;
   logic       stretch_r;
   logic       sda_drv_r;
   logic       wr_acc;
   logic       wr_ctrl;
   logic       clr_flag;
   logic       set_flag;
   logic [7:0] set_code;
   logic       adr_match;
   logic [31:0] rd_w;
   logic        err_w;

   function automatic logic addr_hit(input logic [6:0] a,
                                     input logic [7:0] own);
      addr_hit = (a == own[7:1]) || (own[0] && a == TWS_GC_ADDR);
   endfunction

   // ==========================================================
   // Line sampling
   tws_line_sync u_sync (
      .mclk  (mclk),
      .rst   (rst),
      .scl_i (scl_i),
      .sda_i (sda_i),
      .line  (line)
   );
   // ==========================================================
   // APB access
   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign wr_ctrl = wr_acc && paddr == TWS_OFS_CTRL;
   assign clr_flag = wr_ctrl & pwdata[TWS_CTL_INT];
   tws_apb_regs u_regs (
      .paddr    (paddr),
      .data_q   (data_r),
      .status_q (flag_r ? status_r : TWS_ST_NONE),
      .addr_q   (addr_r),
      .ctrl_q   ({flag_r, ctrl_r[6:0]}),
      .sleep_q  (sleep_r),
      .rdata    (rd_w),
      .slverr   (err_w)
   );
   assign prdata  = (psel & penable & ~pwrite) ? rd_w : 32'h0000_0000;
   assign pslverr = psel & penable & err_w;
   assign irq     = flag_r & ctrl_r[TWS_CTL_IE];
   assign wake    = sleep_r & set_flag;

   // Address match needs acknowledge enable; bus is still watched
   assign adr_match = addr_hit(shift_r[7:1], addr_r) &
                      ctrl_r[TWS_CTL_ACK] & ctrl_r[TWS_CTL_EN];

   // Own address, control and sleep registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         addr_r  <= TWS_RST_ADDR;
         ctrl_r  <= 8'h00;
         sleep_r <= 1'b0;
      end else begin
         if (wr_acc && paddr == TWS_OFS_ADDR)
            addr_r <= pwdata[7:0];
         if (wr_acc && paddr == TWS_OFS_POWER)
            sleep_r <= pwdata[0];
         else if (set_flag)
            sleep_r <= 1'b0;
         if (wr_ctrl)
            ctrl_r <= {1'b0, pwdata[6:0]};
         else if (st_r == TWS_IDLE && ctrl_r[TWS_CTL_STO])
            ctrl_r[TWS_CTL_STO] <= 1'b0;
      end
   end

   // Interrupt flag: hardware set wins over software clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_r   <= 1'b0;
         status_r <= TWS_ST_NONE;
      end else if (set_flag) begin
         flag_r   <= 1'b1;
         status_r <= set_code;
      end else if (clr_flag) begin
         flag_r   <= 1'b0;
      end
   end

   // Data register; a transmit byte is loaded by software
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         data_r <= TWS_RST_DATA;
      else if (wr_acc && paddr == TWS_OFS_DATA)
         data_r <= pwdata[7:0];
   end

   // Pending START request after leaving an addressed state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         start_pend_r <= 1'b0;
      else if (clr_flag && pwdata[TWS_CTL_STA] &&
               (status_r == TWS_ST_DAT_N || status_r == TWS_ST_LAST_A))
         start_pend_r <= 1'b1;
      else if (line.start && !line.scl_fall)
         start_pend_r <= 1'b0;
   end

   // ==========================================================
   // Bus state machine
   always_comb begin
      set_flag = 1'b0;
      set_code = TWS_ST_NONE;
      if (line.start || line.stop) begin
         // Mid-byte in the address phase is as illegal as in data
         if (st_r == TWS_TXB || st_r == TWS_RACK ||
             (st_r == TWS_ADDR && bit_r != 4'h0)) begin
            set_flag = 1'b1;
            set_code = TWS_ST_BUSERR;
         end
      end else if (line.scl_fall) begin
         if (st_r == TWS_AACK) begin
            set_flag = 1'b1;
            set_code = ctrl_r[TWS_CTL_STA] ? TWS_ST_ARB_R
                                           : TWS_ST_SLA_R;
         end else if (st_r == TWS_RACK) begin
            set_flag = 1'b1;
            if (shift_r[0])
               set_code = TWS_ST_DAT_N;
            else if (last_r)
               set_code = TWS_ST_LAST_A;
            else
               set_code = TWS_ST_DAT_A;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r    <= TWS_IDLE;
         shift_r <= 8'h00;
         bit_r   <= 4'h0;
         last_r  <= 1'b0;
      end else if (line.start) begin
         st_r  <= TWS_ADDR;
         bit_r <= 4'h0;
      end else if (line.stop || (clr_flag && pwdata[TWS_CTL_STO])) begin
         st_r <= TWS_IDLE;
      end else begin
         case (st_r)
            TWS_ADDR: if (line.scl_rise) begin
               shift_r <= {shift_r[6:0], line.sda};
               bit_r   <= bit_r + 4'h1;
            end else if (line.scl_fall && bit_r == 4'h8) begin
               // Read bit picks transmit; write or no match goes to TWS_IGN
               st_r <= (adr_match && shift_r[0]) ? TWS_AACK
                                                 : TWS_IGN;
            end
            TWS_AACK: if (line.scl_fall) begin
               st_r  <= TWS_WAIT;
               bit_r <= 4'h0;
            end
            TWS_WAIT: if (clr_flag) begin
               if (status_r == TWS_ST_DAT_N ||
                   status_r == TWS_ST_LAST_A) begin
                  st_r <= TWS_IGN;
               end else begin
                  st_r    <= TWS_TXB;
                  shift_r <= data_r;
                  last_r  <= ~pwdata[TWS_CTL_ACK];
                  bit_r   <= 4'h0;
               end
            end
            TWS_TXB: if (line.scl_fall) begin
               if (bit_r == 4'h7)
                  st_r <= TWS_RACK;
               else
                  shift_r <= {shift_r[6:0], 1'b1};
               bit_r <= bit_r + 4'h1;
            end
            TWS_RACK: if (line.scl_rise) begin
               shift_r[0] <= line.sda;
            end else if (line.scl_fall) begin
               st_r <= TWS_WAIT;
            end
            TWS_IGN: st_r <= TWS_IGN; // Master reads all ones
            default: st_r <= TWS_IDLE;
         endcase
      end
   end

   // Drive SDA and stretch SCL, from flip-flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sda_drv_r <= 1'b0;
         stretch_r <= 1'b0;
      end else begin
         sda_drv_r <= (st_r == TWS_AACK) ||
                      (st_r == TWS_TXB && !shift_r[7]);
         // Freed with the first data bit, never ahead of it (false START)
         stretch_r <= (st_r == TWS_WAIT);
      end
   end
   assign sda_o  = 1'b0;
   assign scl_o  = 1'b0;
   assign sda_oe = sda_drv_r;
   assign scl_oe = stretch_r & ~line.scl_rise;

   // ==========================================================
   // Checks
   a_flag_sets_status: assert property (
      @(posedge mclk) disable iff (rst)
      set_flag |=> flag_r && status_r == $past(set_code))
      else $error("flag or status not set");
   a_none_when_clear: assert property (
      @(posedge mclk) disable iff (rst)
      !flag_r |-> u_regs.status_q == TWS_ST_NONE)
      else $error("idle status wrong");
   a_stretch_on_flag: assert property (
      @(posedge mclk) disable iff (rst)
      (st_r == TWS_WAIT && !clr_flag) |=> stretch_r)
      else $error("clock not held");
   a_ign_no_drive: assert property (
      @(posedge mclk) disable iff (rst)
      st_r == TWS_IGN ##1 st_r == TWS_IGN |-> !sda_oe)
      else $error("driving while ignoring");
   // An address byte seen with acknowledge off never leads to an ACK
   a_ack_gate_addr: assert property (
      @(posedge mclk) disable iff (rst)
      (st_r == TWS_ADDR && !ctrl_r[TWS_CTL_ACK] && line.scl_fall &&
       bit_r == 4'h8 && !line.start && !line.stop) |=> st_r != TWS_AACK)
      else $error("matched with acknowledge off");
   a_last_c8_code: assert property (
      @(posedge mclk) disable iff (rst)
      (set_flag && st_r == TWS_RACK && !shift_r[0] && last_r &&
       !line.start && !line.stop) |=> status_r == TWS_ST_LAST_A)
      else $error("last byte status wrong");
   a_nack_c0_code: assert property (
      @(posedge mclk) disable iff (rst)
      (set_flag && st_r == TWS_RACK && shift_r[0] && !line.start &&
       !line.stop) |=> status_r == TWS_ST_DAT_N)
      else $error("nack status wrong");
   a_wake_on_match: assert property (
      @(posedge mclk) disable iff (rst)
      (sleep_r && set_flag) |-> wake ##1 !sleep_r)
      else $error("no wake");
   // Misplaced START or STOP inside a byte or a data byte's acknowledge
   a_bus_error_code: assert property (
      @(posedge mclk) disable iff (rst)
      ((line.start || line.stop) && (st_r == TWS_TXB || st_r == TWS_RACK ||
       (st_r == TWS_ADDR && bit_r != 4'h0))) |=> status_r == TWS_ST_BUSERR)
      else $error("bus error not flagged");
   // Clearing after a refused byte leaves the transfer for good
   a_ign_after_nack: assert property (
      @(posedge mclk) disable iff (rst)
      (st_r == TWS_WAIT && clr_flag && !line.start && !line.stop &&
       !pwdata[TWS_CTL_STO] && status_r == TWS_ST_DAT_N) |=> st_r == TWS_IGN)
      else $error("still addressed after refusal");
   a_start_pending: assert property (
      @(posedge mclk) disable iff (rst)
      (clr_flag && pwdata[TWS_CTL_STA] &&
       (status_r == TWS_ST_DAT_N || status_r == TWS_ST_LAST_A))
      |=> start_pend_r)
      else $error("start request not kept");
   // SCL must never be freed before the first data bit is on SDA
   a_release_with_data: assert property (
      @(posedge mclk) disable iff (rst)
      ($fell(stretch_r) && st_r == TWS_TXB) |-> sda_oe == !shift_r[7])
      else $error("clock freed before data bit");
   c_addressed: cover property (@(posedge mclk) disable iff (rst)
      set_flag && set_code == TWS_ST_SLA_R);
   c_byte_acked: cover property (@(posedge mclk) disable iff (rst)
      set_flag && set_code == TWS_ST_DAT_A);
   c_bus_error: cover property (@(posedge mclk) disable iff (rst)
      set_flag && set_code == TWS_ST_BUSERR);
   c_arb_lost: cover property (@(posedge mclk) disable iff (rst)
      set_flag && set_code == TWS_ST_ARB_R);
   c_last_acked: cover property (@(posedge mclk) disable iff (rst)
      set_flag && set_code == TWS_ST_LAST_A);
endmodule
`default_nettype wire

// ### verification/tws_master_model.sv
/*
 Behavioural two-wire bus master receiver that faces the slave transmitter.
 Assumes open-drain lines resolved with pull-ups by the bench; oe high pulls.
*/
`timescale 1ns/100ps
`default_nettype none
module tws_master_model (
   input  wire logic scl,
   input  wire logic sda,
   output var  logic scl_oe_m,
   output var  logic sda_oe_m
);
   // ==========================================================
   // Line phases, a 48 ns bit with quarter steps
   initial begin
      scl_oe_m = 1'b0;
      sda_oe_m = 1'b0;
   end

   // START from any phase: free SDA, raise SCL, then pull SDA
   task automatic start_c();
      sda_oe_m = 1'b0;
      #12;
      scl_oe_m = 1'b0;
      wait (scl === 1'b1);
      #12;
      sda_oe_m = 1'b1;
      #12;
      scl_oe_m = 1'b1;
      #12;
   endtask

   // STOP: SDA low, SCL up, then free SDA
   task automatic stop_c();
      sda_oe_m = 1'b1;
      #12;
      scl_oe_m = 1'b0;
      wait (scl === 1'b1);
      #12;
      sda_oe_m = 1'b0;
      #24;
   endtask

   // One bit; waits while the slave stretches the clock
   task automatic bit_c(input logic b, output logic q);
      sda_oe_m = !b;
      #12;
      scl_oe_m = 1'b0;
      wait (scl === 1'b1);
      #12;
      q = sda;
      #12;
      scl_oe_m = 1'b1;
      #12;
   endtask
endmodule
`default_nettype wire

// ### verification/two_wire_slave_transmitter_bench.sv
/*
 Self-checking bench for the two-wire slave transmitter.
 Assumes the design package, the top module and the master model.
*/
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_transmitter_bench;
   import tws_pkg::*;
   typedef struct packed {
      logic       w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] x;
      logic       e;
   } tws_row_s;
   localparam tws_row_s ROWS [9] = '{
      '{1'b0, TWS_OFS_STATUS, 8'h00, 8'hF8, 1'b0},
      '{1'b0, TWS_OFS_DATA,   8'h00, 8'hFF, 1'b0},
      '{1'b0, TWS_OFS_ADDR,   8'h00, 8'h00, 1'b0},
      '{1'b1, TWS_OFS_ADDR,   8'h53, 8'h00, 1'b0},
      '{1'b0, TWS_OFS_ADDR,   8'h00, 8'h53, 1'b0},
      '{1'b1, TWS_OFS_DATA,   8'h5A, 8'h00, 1'b0},
      '{1'b0, TWS_OFS_DATA,   8'h00, 8'h5A, 1'b0},
      '{1'b1, 8'h14,          8'h00, 8'h00, 1'b1},
      '{1'b0, 8'h14,          8'h00, 8'h00, 1'b1}};
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        scl_o, scl_oe, sda_o, sda_oe, wake, irq, er, aq, q;
   logic        scl_oe_m, sda_oe_m, wake_seen;
   logic [7:0]  got [3];
   wire logic   scl_w, sda_w;
   int          err_total, num_checks, cyc;

   // Open-drain lines with pull-ups
   assign scl_w = !(scl_oe | scl_oe_m);
   assign sda_w = !(sda_oe | sda_oe_m);

   tws_top i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .wake(wake), .irq(irq));
   tws_master_model i_mst (.scl(scl_w), .sda(sda_w), .scl_oe_m(scl_oe_m),
      .sda_oe_m(sda_oe_m));

   // ==========================================================
   // Clock, wake capture and hang guard
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (wake === 1'b1) wake_seen <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         give_verdict();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // One APB transfer; waits for pready at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Software step: wait flag, check status, load byte, clear flag
   task automatic serve(input logic [7:0] st, input logic [7:0] d,
                        input logic [7:0] c);
      // The previous clear lands at this edge; look from the next one on
      @(posedge mclk);
      while (irq !== 1'b1) @(posedge mclk);
      apb(1'b0, TWS_OFS_STATUS, 8'h00);
      chk(rd & 32'h0000_00F8, {24'h00_0000, st});
      if (st !== TWS_ST_BUSERR) chk(32'(scl_oe), 32'h0000_0001);
      if (d !== 8'h00) apb(1'b1, TWS_OFS_DATA, d);
      apb(1'b1, TWS_OFS_CTRL, c);
   endtask

   // Master read frame: address byte, n bytes, last ack as given
   task automatic mread(input logic [7:0] own_address, input int n, input logic lack);
      i_mst.start_c();
      for (int i = 7; i >= 0; i--) i_mst.bit_c(own_address[i], q);
      i_mst.bit_c(1'b1, aq);
      for (int k = 0; k < n && aq === 1'b0; k++) begin
         for (int i = 7; i >= 0; i--) i_mst.bit_c(1'b1, got[k][i]);
         i_mst.bit_c(k < n - 1 ? 1'b0 : lack, q);
      end
      i_mst.stop_c();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      wake_seen = 1'b0;
      err_total = 0;
      num_checks = 0;
      cyc = 0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         chk(32'(er), 32'(ROWS[i].e));
         if (!ROWS[i].w) chk(rd, {24'h00_0000, ROWS[i].x});
      end
      $display("register table done");
      apb(1'b1, TWS_OFS_CTRL, 8'h45);
      // Two bytes, last one refused by the master
      fork
         mread(8'h53, 2, 1'b1);
         begin
            serve(TWS_ST_SLA_R, 8'h3C, 8'hC5);
            serve(TWS_ST_DAT_A, 8'h96, 8'h85);
            serve(TWS_ST_DAT_N, 8'h00, 8'hC5);
         end
      join
      chk(32'(aq), 32'h0000_0000);
      chk({24'h00_0000, got[0]}, 32'h0000_003C);
      chk({24'h00_0000, got[1]}, 32'h0000_0096);
      $display("read with refusal done");
      // Master acks the last byte, then reads on and sees ones
      fork
         mread(8'h53, 3, 1'b1);
         begin
            serve(TWS_ST_SLA_R, 8'h3C, 8'hC5);
            serve(TWS_ST_DAT_A, 8'h96, 8'h85);
            serve(TWS_ST_LAST_A, 8'h00, 8'hC5);
         end
      join
      chk({24'h00_0000, got[2]}, 32'h0000_00FF);
      apb(1'b0, TWS_OFS_STATUS, 8'h00);
      chk(rd & 32'h0000_00F8, 32'h0000_00F8);
      $display("last byte acked done");
      // Acknowledge off isolates the device
      apb(1'b1, TWS_OFS_CTRL, 8'h05);
      mread(8'h53, 1, 1'b1);
      chk(32'(aq), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, TWS_OFS_CTRL, 8'h45);
      // Own address with the write bit is not taken for transmit
      mread(8'h52, 1, 1'b1);
      chk(32'(aq), 32'h0000_0001);
      // General call, enabled then disabled
      fork
         mread(8'h01, 1, 1'b1);
         begin
            serve(TWS_ST_SLA_R, 8'h77, 8'h85);
            serve(TWS_ST_DAT_N, 8'h00, 8'hC5);
         end
      join
      chk({24'h00_0000, got[0]}, 32'h0000_0077);
      apb(1'b1, TWS_OFS_ADDR, 8'h52);
      mread(8'h01, 1, 1'b1);
      chk(32'(aq), 32'h0000_0001);
      apb(1'b1, TWS_OFS_ADDR, 8'h53);
      $display("isolation and general call done");
      // Addressed while a start request is pending
      apb(1'b1, TWS_OFS_CTRL, 8'h65);
      fork
         mread(8'h53, 1, 1'b1);
         begin
            serve(TWS_ST_ARB_R, 8'h11, 8'h85);
            serve(TWS_ST_DAT_N, 8'h00, 8'hE5);
         end
      join
      chk({24'h00_0000, got[0]}, 32'h0000_0011);
      apb(1'b0, TWS_OFS_CTRL, 8'h00);
      chk(rd, 32'h0000_0065);
      apb(1'b1, TWS_OFS_CTRL, 8'h45);
      // Address match in sleep wakes the part, clock held
      apb(1'b1, TWS_OFS_POWER, 8'h01);
      wake_seen <= 1'b0;
      fork
         mread(8'h53, 1, 1'b1);
         begin
            serve(TWS_ST_SLA_R, 8'h22, 8'h85);
            serve(TWS_ST_DAT_N, 8'h00, 8'hC5);
         end
      join
      chk(32'(wake_seen), 32'h0000_0001);
      chk({24'h00_0000, got[0]}, 32'h0000_0022);
      apb(1'b0, TWS_OFS_POWER, 8'h00);
      chk(rd & 32'h0000_0001, 32'h0000_0000);
      $display("arbitration and sleep done");
      // Repeated START inside the address byte
      i_mst.start_c();
      for (int i = 0; i < 3; i++) i_mst.bit_c(1'b1, q);
      i_mst.start_c();
      serve(TWS_ST_BUSERR, 8'h00, 8'hD5);
      i_mst.stop_c();
      apb(1'b0, TWS_OFS_STATUS, 8'h00);
      chk(rd & 32'h0000_00F8, 32'h0000_00F8);
      chk(32'(scl_oe | sda_oe), 32'h0000_0000);
      $display("bus error done");
      give_verdict();
   end
endmodule
`default_nettype wire
